// [core/backplane_scan_exchange_mailbox_consts.vh]
// Constants for the backplane scan exchange mailbox.
// Assumes inclusion by bare name from the design file.
`ifndef BACKPLANE_SCAN_EXCHANGE_MAILBOX_CONSTS_VH
`define BACKPLANE_SCAN_EXCHANGE_MAILBOX_CONSTS_VH

// ****************************************
// Area and mailbox geometry
// ****************************************
`define AREA_MAX      12'hFA0
`define MBOX_WORDS    12'h040
`define DB_WORDS      12'hF60
`define SEQ_WORD      6'h00
`define ID_WORD       6'h01
`define ARG_WORD      6'h02

// ****************************************
// Block identifiers
// ****************************************
`define ID_EVENT      16'h26E6
`define ID_TIME_RD    16'h26F2
`define ID_TIME_WR    16'h26F3
`define ID_WARM       16'h270E
`define ID_COLD       16'h270F

// ****************************************
// Event block layout and queues
// ****************************************
`define EV_COUNT_WORD 6'h02
`define EV_BASE       6'h03
`define EV_STRIDE     6'h0F
`define EV_ASDU       6'h01
`define EV_DATA       6'h09
`define EV_MAX        3'h4
`define EV_TYPES      3'h6
`define QDEPTH        7'h63
`define QLAST         7'h62

`define ASDU_SP       16'h0001
`define ASDU_DP       16'h0003
`define ASDU_ST       16'h0005
`define ASDU_NM       16'h0009
`define ASDU_SC       16'h000B
`define ASDU_IT       16'h000F

`endif

// [core/backplane_scan_exchange_mailbox.v]
// Scan exchange engine between the module database and the processor word areas.
// Assumes a word-wide processor memory port answering each request with bp_ack.
`timescale 1ns/1ps
`default_nettype none
`include "backplane_scan_exchange_mailbox_consts.vh"

module backplane_scan_exchange_mailbox (
  input  wire        mclk,           // 100 MHz clock
  input  wire        resetn,         // Async reset, active low
  input  wire [15:0] cfg_rd_start,   // First input word of read area
  input  wire [11:0] cfg_rd_count,   // Words in read area
  input  wire [15:0] cfg_wr_start,   // First holding word of write area
  input  wire [11:0] cfg_wr_count,   // Words in write area
  input  wire        scan_end,       // Processor scan end pulse
  output reg         scan_hold_r,    // Holds processor scan
  output reg         bp_req_r,       // Word access request
  output reg         bp_we_r,        // 1 writes input word area
  output reg  [15:0] bp_addr_r,      // Processor word address
  output reg  [15:0] bp_wdata_r,     // Word to processor
  input  wire        bp_ack,         // Access done pulse
  input  wire [15:0] bp_rdata,       // Word from processor, valid with ack
  input  wire        rdb_we,         // Load read database word
  input  wire [11:0] rdb_addr,       // Read database index
  input  wire [15:0] rdb_wdata,      // Read database data
  input  wire [11:0] wdb_addr,       // Write database index
  output reg  [15:0] wdb_rdata_r,    // Write database word, one cycle later
  input  wire [95:0] now_time,       // Module time, six words
  output reg         set_time_r,     // Time set pulse
  output reg  [95:0] set_time_val_r, // Time from processor
  output reg         warm_boot_r,    // Warm restart pulse
  output reg         cold_boot_r,    // Cold restart pulse
  input  wire        ev_pop,         // Take oldest event of a type
  input  wire [2:0]  ev_pop_type,    // Event type index 0..5
  output reg  [47:0] ev_out_r,       // Index, data0, data1
  output reg         ev_out_valid_r  // Event word valid pulse
);

  // ****************************************
  // States and storage
  // ****************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_TAKE = 3'h1;
  localparam [2:0] S_DEC  = 3'h2;
  localparam [2:0] S_EVT  = 3'h3;
  localparam [2:0] S_GIVE = 3'h4;

  reg [2:0]  state_r;
  reg [11:0] idx_r;
  reg [15:0] last_seq_r;
  reg        seq_seen_r;
  reg [2:0]  ev_k_r;
  reg [41:0] head_r;
  reg [41:0] cnt_r;
  reg [41:0] head_nxt;
  reg [41:0] cnt_nxt;

  reg [15:0] req_mem [0:63];
  reg [15:0] resp_r  [0:63];
  reg [15:0] rd_db   [0:3935];
  reg [15:0] wr_db   [0:3935];
  reg [47:0] ev_mem  [0:593];

  integer i;
  integer k;

  wire [11:0] rd_cnt = (cfg_rd_count > `AREA_MAX) ? `AREA_MAX : cfg_rd_count;
  wire [11:0] wr_cnt = (cfg_wr_count > `AREA_MAX) ? `AREA_MAX : cfg_wr_count;
  wire        in_mbox = (idx_r < `MBOX_WORDS);
  wire [11:0] db_idx  = idx_r - `MBOX_WORDS;
  wire        take_ack = (state_r == S_TAKE) && bp_req_r && bp_ack;
  wire [15:0] give_word = in_mbox ? resp_r[idx_r[5:0]] : rd_db[db_idx];
  wire [15:0] req_seq = req_mem[`SEQ_WORD];
  wire [15:0] req_id  = req_mem[`ID_WORD];

  // ****************************************
  // Event push decode
  // ****************************************
  wire [2:0] ev_num = (req_mem[`EV_COUNT_WORD] > {13'h0, `EV_MAX}) ? `EV_MAX :
                      req_mem[`EV_COUNT_WORD][2:0];
  wire [5:0] ev_base = `EV_BASE + ev_k_r * `EV_STRIDE;
  wire [15:0] ev_asdu = req_mem[ev_base + `EV_ASDU];
  reg  [2:0] push_type;
  reg        push_ok;

  always @* begin
    push_ok = 1'b1;
    case (ev_asdu)
      `ASDU_SP: push_type = 3'h0;
      `ASDU_DP: push_type = 3'h1;
      `ASDU_ST: push_type = 3'h2;
      `ASDU_NM: push_type = 3'h3;
      `ASDU_SC: push_type = 3'h4;
      `ASDU_IT: push_type = 3'h5;
      default: begin
        push_type = 3'h0;
        push_ok   = 1'b0;
      end
    endcase
  end

  wire push = (state_r == S_EVT) && (ev_k_r < ev_num) && push_ok;
  wire [47:0] push_rec = {req_mem[ev_base], req_mem[ev_base + `EV_DATA],
                          req_mem[ev_base + `EV_DATA + 6'h01]};
  wire [6:0] p_head = head_r[push_type*7 +: 7];
  wire [6:0] p_cnt  = cnt_r[push_type*7 +: 7];
  wire [7:0] p_sum  = {1'b0, p_head} + {1'b0, p_cnt};
  wire [7:0] p_slot = (p_sum >= {1'b0, `QDEPTH}) ? p_sum - {1'b0, `QDEPTH} : p_sum;
  wire [9:0] push_addr = push_type * `QDEPTH + {2'h0, p_slot};
  wire [6:0] o_head = head_r[ev_pop_type*7 +: 7];
  wire       pop = ev_pop && (ev_pop_type < `EV_TYPES) &&
                   (cnt_r[ev_pop_type*7 +: 7] != 7'h00);
  wire [9:0] pop_addr = ev_pop_type * `QDEPTH + {3'h0, o_head};

  always @* begin
    head_nxt = head_r;
    cnt_nxt  = cnt_r;
    // Own loop variable: sharing one with the clocked process gives it two drivers
    for (k = 0; k < `EV_TYPES; k = k + 1) begin
      if (pop && ev_pop_type == k) begin
        head_nxt[k*7 +: 7] = (head_nxt[k*7 +: 7] == `QLAST) ? 7'h00 :
                             head_nxt[k*7 +: 7] + 7'h01;
        cnt_nxt[k*7 +: 7]  = cnt_nxt[k*7 +: 7] - 7'h01;
      end
      if (push && push_type == k) begin
        if (cnt_nxt[k*7 +: 7] == `QDEPTH) begin
          head_nxt[k*7 +: 7] = (head_nxt[k*7 +: 7] == `QLAST) ? 7'h00 :
                               head_nxt[k*7 +: 7] + 7'h01;
        end else begin
          cnt_nxt[k*7 +: 7] = cnt_nxt[k*7 +: 7] + 7'h01;
        end
      end
    end
  end

  // ****************************************
  // Memories without reset
  // ****************************************
  always @(posedge mclk) begin
    if (take_ack) begin
      if (in_mbox) begin
        req_mem[idx_r[5:0]] <= bp_rdata;
      end else begin
        wr_db[db_idx] <= bp_rdata;
      end
    end
    if (rdb_we && rdb_addr < `DB_WORDS) begin
      rd_db[rdb_addr] <= rdb_wdata;
    end
    if (push) begin
      ev_mem[push_addr] <= push_rec;
    end
  end

  // ****************************************
  // Scan sequencer
  // ****************************************
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r        <= S_IDLE;
      idx_r          <= 12'h000;
      scan_hold_r    <= 1'b0;
      bp_req_r       <= 1'b0;
      bp_we_r        <= 1'b0;
      bp_addr_r      <= 16'h0000;
      bp_wdata_r     <= 16'h0000;
      last_seq_r     <= 16'h0000;
      seq_seen_r     <= 1'b0;
      ev_k_r         <= 3'h0;
      set_time_r     <= 1'b0;
      set_time_val_r <= 96'h0;
      warm_boot_r    <= 1'b0;
      cold_boot_r    <= 1'b0;
      wdb_rdata_r    <= 16'h0000;
      ev_out_r       <= 48'h0;
      ev_out_valid_r <= 1'b0;
      head_r         <= 42'h0;
      cnt_r          <= 42'h0;
      for (i = 0; i < 64; i = i + 1) begin
        resp_r[i] <= 16'h0000;
      end
    end else begin
      set_time_r     <= 1'b0;
      warm_boot_r    <= 1'b0;
      cold_boot_r    <= 1'b0;
      ev_out_valid_r <= pop;
      head_r         <= head_nxt;
      cnt_r          <= cnt_nxt;
      wdb_rdata_r    <= (wdb_addr < `DB_WORDS) ? wr_db[wdb_addr] : 16'h0000;
      if (pop) begin
        ev_out_r <= ev_mem[pop_addr];
      end
      case (state_r)
        S_IDLE: begin
          if (scan_end) begin
            scan_hold_r <= 1'b1;
            idx_r       <= 12'h000;
            state_r     <= S_TAKE;
          end
        end
        S_TAKE: begin
          if (!bp_req_r) begin
            if (idx_r < wr_cnt) begin
              bp_req_r  <= 1'b1;
              bp_we_r   <= 1'b0;
              bp_addr_r <= cfg_wr_start + {4'h0, idx_r};
            end else begin
              idx_r   <= 12'h000;
              state_r <= S_DEC;
            end
          end else if (bp_ack) begin
            bp_req_r <= 1'b0;
            idx_r    <= idx_r + 12'h001;
          end
        end
        S_DEC: begin
          state_r <= S_GIVE;
          if (wr_cnt >= `MBOX_WORDS) begin
            seq_seen_r <= 1'b1;
            last_seq_r <= req_seq;
          end
          if (wr_cnt >= `MBOX_WORDS && seq_seen_r && req_seq != last_seq_r) begin
            case (req_id)
              `ID_EVENT: begin
                ev_k_r  <= 3'h0;
                state_r <= S_EVT;
              end
              `ID_TIME_RD: begin
                for (i = 0; i < 6; i = i + 1) begin
                  resp_r[`ARG_WORD + i] <= now_time[i*16 +: 16];
                end
              end
              `ID_TIME_WR: begin
                set_time_r <= 1'b1;
                for (i = 0; i < 6; i = i + 1) begin
                  set_time_val_r[i*16 +: 16] <= req_mem[`ARG_WORD + i];
                end
              end
              `ID_WARM: warm_boot_r <= 1'b1;
              `ID_COLD: cold_boot_r <= 1'b1;
              default: ;
            endcase
            if (req_id == `ID_EVENT || req_id == `ID_TIME_RD ||
                req_id == `ID_TIME_WR || req_id == `ID_WARM ||
                req_id == `ID_COLD) begin
              resp_r[`SEQ_WORD] <= req_seq + 16'h0001;
              resp_r[`ID_WORD]  <= req_id;
            end
          end
        end
        S_EVT: begin
          if (ev_k_r < ev_num) begin
            ev_k_r <= ev_k_r + 3'h1;
          end else begin
            state_r <= S_GIVE;
          end
        end
        S_GIVE: begin
          if (!bp_req_r) begin
            if (idx_r < rd_cnt) begin
              bp_req_r   <= 1'b1;
              bp_we_r    <= 1'b1;
              bp_addr_r  <= cfg_rd_start + {4'h0, idx_r};
              bp_wdata_r <= give_word;
            end else begin
              idx_r       <= 12'h000;
              scan_hold_r <= 1'b0;
              state_r     <= S_IDLE;
            end
          end else if (bp_ack) begin
            bp_req_r <= 1'b0;
            bp_we_r  <= 1'b0;
            idx_r    <= idx_r + 12'h001;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// [dv/mbox_props.sv]
// Port checker for the scan exchange mailbox.
// Assumes one clock domain and the design's own port names.
`timescale 1ns/1ps
`default_nettype none
module mbox_props (
  input wire logic        mclk,           // Clock
  input wire logic        resetn,         // Async reset, active low
  input wire logic        scan_end,       // Scan end pulse
  input wire logic        scan_hold_r,    // Scan hold
  input wire logic        bp_req_r,       // Word request
  input wire logic        bp_we_r,        // Write direction
  input wire logic        bp_ack,         // Access done
  input wire logic        set_time_r,     // Time set pulse
  input wire logic        warm_boot_r,    // Warm restart pulse
  input wire logic        cold_boot_r,    // Cold restart pulse
  input wire logic        ev_pop,         // Event pop
  input wire logic        ev_out_valid_r, // Event out valid
  input wire logic [15:0] cfg_rd_start,   // Read area start
  input wire logic [15:0] cfg_wr_start,   // Write area start
  input wire logic [15:0] bp_addr_r,      // Request address
  input wire logic [15:0] bp_wdata_r,     // Request data
  input wire logic [11:0] cfg_rd_count,   // Read area size
  input wire logic [11:0] cfg_wr_count    // Write area size
);
  // ****************************************
  // Port relations
  // ****************************************
  wire [15:0] wo = bp_addr_r - cfg_wr_start;
  wire [15:0] ro = bp_addr_r - cfg_rd_start;
  wire        pl = set_time_r | warm_boot_r | cold_boot_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_hold_on_end: assert property (scan_end && !scan_hold_r |=> scan_hold_r)
    else $error("scan end not held");
  a_first_take: assert property ($rose(scan_hold_r) && cfg_wr_count != 12'h000
    |=> bp_req_r && !bp_we_r && bp_addr_r == cfg_wr_start) else $error("first take wrong");
  a_req_steady: assert property (bp_req_r && !bp_ack |=> bp_req_r && $stable(bp_addr_r)
    && $stable(bp_we_r) && $stable(bp_wdata_r)) else $error("request moved");
  a_req_done: assert property (bp_req_r && bp_ack |=> !bp_req_r)
    else $error("request kept after ack");
  a_req_in_scan: assert property (bp_req_r |-> scan_hold_r)
    else $error("access outside held scan");
  a_take_range: assert property (bp_req_r && !bp_we_r |-> wo < {4'h0, cfg_wr_count})
    else $error("take outside write area");
  a_give_range: assert property (bp_req_r && bp_we_r |-> ro < {4'h0, cfg_rd_count})
    else $error("give outside read area");
  a_pulse_scan: assert property (pl |-> scan_hold_r && $onehot({set_time_r, warm_boot_r,
    cold_boot_r}) ##1 !pl) else $error("command pulse wrong");
  a_pop_answer: assert property (ev_out_valid_r |-> $past(ev_pop))
    else $error("event out without pop");
  c_scan: cover property ($fell(scan_hold_r));
  c_boot: cover property (warm_boot_r);
  c_pop: cover property (ev_out_valid_r);
endmodule
bind backplane_scan_exchange_mailbox mbox_props chk (.mclk, .resetn, .scan_end, .scan_hold_r,
  .bp_req_r, .bp_we_r, .bp_ack, .set_time_r, .warm_boot_r, .cold_boot_r, .ev_pop,
  .ev_out_valid_r, .cfg_rd_start, .cfg_wr_start, .bp_addr_r, .bp_wdata_r, .cfg_rd_count,
  .cfg_wr_count);
`default_nettype wire

// [dv/proc_mem_model.sv]
// Processor word memory answering the backplane port.
// Assumes the bench preloads hold_mem and picks the latency.
`timescale 1ns/1ps
`default_nettype none
module proc_mem_model (
  input  wire logic        mclk,      // Clock
  input  wire logic        resetn,    // Async reset, active low
  input  wire logic        bp_req_r,  // Word request
  input  wire logic        bp_we_r,   // Write direction
  input  wire logic [15:0] bp_addr_r, // Word address
  input  wire logic [1:0]  lat,       // Extra wait cycles
  output logic             bp_ack,    // Done pulse
  output logic      [15:0] bp_rdata   // Read word
);
  logic [15:0] hold_mem [0:65535];
  logic [1:0]  wt;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bp_ack <= 1'b0;
      wt <= 2'h0;
      bp_rdata <= 16'h5A5A;
    end else if (bp_req_r && !bp_ack && wt >= lat) begin
      bp_ack <= 1'b1;
      wt <= 2'h0;
      if (!bp_we_r) bp_rdata <= hold_mem[bp_addr_r];
    end else begin
      // Stale data is inverted so nothing can read it by luck
      bp_ack <= 1'b0;
      bp_rdata <= ~bp_rdata;
      wt <= (bp_req_r && !bp_ack) ? wt + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the scan exchange mailbox.
// Assumes the memory model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`include "backplane_scan_exchange_mailbox_consts.vh"
module testbench;
  logic        mclk, resetn, scan_end, rdb_we, ev_pop;
  logic [15:0] cfg_rd_start, cfg_wr_start, rdb_wdata, seq;
  logic [11:0] cfg_rd_count, cfg_wr_count, rdb_addr, wdb_addr;
  logic [2:0]  ev_pop_type;
  logic [1:0]  lat;
  logic [95:0] now_time, tval;
  logic [15:0] resp [0:63];
  logic [15:0] rdbm [0:3935];
  logic [31:0] exp_wr [$];
  logic [98:0] exp_pl [$];
  logic [47:0] exp_ev [$];
  wire         bp_ack, bp_req_r, bp_we_r, scan_hold_r, set_time_r, warm_boot_r, cold_boot_r;
  wire         ev_out_valid_r;
  wire  [15:0] bp_rdata, bp_addr_r, bp_wdata_r, wdb_rdata_r;
  wire  [95:0] set_time_val_r;
  wire  [47:0] ev_out_r;
  integer      error_cnt = 0, checked = 0, seed = 32'hA132BB73, cyc = 0, i, r, e;
  backplane_scan_exchange_mailbox uut (.mclk, .resetn, .cfg_rd_start, .cfg_rd_count,
    .cfg_wr_start, .cfg_wr_count, .scan_end, .scan_hold_r, .bp_req_r, .bp_we_r, .bp_addr_r,
    .bp_wdata_r, .bp_ack, .bp_rdata, .rdb_we, .rdb_addr, .rdb_wdata, .wdb_addr, .wdb_rdata_r,
    .now_time, .set_time_r, .set_time_val_r, .warm_boot_r, .cold_boot_r, .ev_pop,
    .ev_pop_type, .ev_out_r, .ev_out_valid_r);
  proc_mem_model pm (.mclk, .resetn, .bp_req_r, .bp_we_r, .bp_addr_r, .lat, .bp_ack, .bp_rdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [98:0] got, input logic [98:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge mclk) begin
    if (bp_req_r && bp_ack && bp_we_r)
      chk({bp_addr_r, bp_wdata_r}, exp_wr.size() ? exp_wr.pop_front() : 'x);
    if (set_time_r || warm_boot_r || cold_boot_r)
      chk({set_time_r, warm_boot_r, cold_boot_r, set_time_val_r},
          exp_pl.size() ? exp_pl.pop_front() : 'x);
    if (ev_out_valid_r) chk(ev_out_r, exp_ev.size() ? exp_ev.pop_front() : 'x);
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      conclude();
    end
  end
  // Area word i below 64 is mailbox, above it database word i-64
  task automatic scan();
    integer n;
    for (n = 0; n < cfg_rd_count; n++)
      exp_wr.push_back({cfg_rd_start + n[15:0], n < 64 ? resp[n] : rdbm[n - 64]});
    lat = $random(seed);
    @(negedge mclk) scan_end = 1'b1;
    @(negedge mclk) scan_end = 1'b0;
    n = 0;
    // Full areas at the longest wait need about 48000 cycles
    while (scan_hold_r !== 1'b0 && n < 60000) begin
      @(negedge mclk);
      n++;
    end
    chk(scan_hold_r, 1'b0);
  endtask
  // Request words are in place before the sequence word moves
  task automatic req(input logic [15:0] id, input logic bump);
    pm.hold_mem[16'h2001] = id;
    if (bump) begin
      seq = seq + 16'h0001;
      pm.hold_mem[16'h2000] = seq;
      if (id inside {`ID_EVENT, `ID_TIME_RD, `ID_TIME_WR, `ID_WARM, `ID_COLD}) begin
        resp[0] = seq + 16'h0001;
        resp[1] = id;
      end
      for (i = 0; i < 6; i++) begin
        if (id == `ID_TIME_RD) resp[2 + i] = now_time[16 * i +: 16];
        if (id == `ID_TIME_WR) tval[16 * i +: 16] = pm.hold_mem[16'h2002 + i];
      end
      if (id == `ID_TIME_WR) exp_pl.push_back({3'b100, tval});
      if (id == `ID_WARM) exp_pl.push_back({3'b010, tval});
      if (id == `ID_COLD) exp_pl.push_back({3'b001, tval});
    end
    scan();
  endtask
  task automatic wdb(input logic [11:0] a);
    wdb_addr = a;
    @(negedge mclk);
    chk(wdb_rdata_r, pm.hold_mem[16'h2040 + a]);
  endtask
  task automatic pop(input logic [2:0] t);
    ev_pop = 1'b1;
    ev_pop_type = t;
    @(negedge mclk) ev_pop = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  initial begin
    {resetn, scan_end, rdb_we, ev_pop, ev_pop_type, lat, rdb_addr, rdb_wdata, wdb_addr} = '0;
    {cfg_rd_start, cfg_rd_count, cfg_wr_start, cfg_wr_count} = {16'h1000, 12'h046, 16'h2000,
                                                                12'h046};
    now_time = {$random(seed), $random(seed), $random(seed)};
    tval = '0;
    for (i = 0; i < 64; i++) resp[i] = 16'h0000;
    for (i = 0; i < 65536; i++) pm.hold_mem[i] = $random(seed);
    seq = pm.hold_mem[16'h2000];
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    for (i = 0; i < 3936; i++) begin
      rdbm[i] = $random(seed);
      {rdb_we, rdb_addr, rdb_wdata} = {1'b1, i[11:0], rdbm[i]};
      @(negedge mclk);
    end
    rdb_we = 1'b0;
    scan();
    for (i = 0; i < 6; i++) wdb(i[11:0]);
    // Every command but the event one, then an unknown one and an unchanged sequence
    req(`ID_TIME_RD, 1'b1);
    req(`ID_TIME_WR, 1'b1);
    req(`ID_WARM, 1'b1);
    req(`ID_COLD, 1'b1);
    req(16'h1234, 1'b1);
    req(`ID_WARM, 1'b0);
    for (r = 0; r < 25; r++) begin
      pm.hold_mem[16'h2002] = 16'h0004;
      for (e = 0; e < 4; e++) begin
        i = 16'h2003 + 15 * e;
        {pm.hold_mem[i], pm.hold_mem[i + 1]} = {16'(4 * r + e), `ASDU_SP};
        {pm.hold_mem[i + 9], pm.hold_mem[i + 10]} = {16'(4 * r + e), ~16'(4 * r + e)};
      end
      req(`ID_EVENT, 1'b1);
    end
    // One double-point event lands in its own queue
    pm.hold_mem[16'h2002] = 16'h0001;
    {pm.hold_mem[16'h2003], pm.hold_mem[16'h2004]} = {16'h0055, `ASDU_DP};
    {pm.hold_mem[16'h200C], pm.hold_mem[16'h200D]} = {16'h0055, 16'h00AA};
    req(`ID_EVENT, 1'b1);
    exp_ev.push_back({16'h0001, 16'h0001, 16'hFFFE});
    exp_ev.push_back({16'h0055, 16'h0055, 16'h00AA});
    pop(3'h0);
    pop(3'h1);
    pop(3'h2);
    {cfg_rd_count, cfg_wr_count} = {12'hFA0, 12'hFA0};
    scan();
    wdb(12'hF5F);
    chk(exp_wr.size() + exp_pl.size() + exp_ev.size(), 0);
    conclude();
  end
endmodule
`default_nettype wire
